// ---- logic/clock_ctl_pkg.sv ----
// package: register map, field layout, reset values and counts of the clock controller
package clock_ctl_pkg;
    // ----------------------------------------
    // register indices and byte addresses
    // ----------------------------------------
    localparam int IDX_CTRL_A = 'h00;
    localparam int IDX_CTRL_B = 'h01;
    localparam int IDX_LOCK = 'h02;
    localparam int IDX_STATUS = 'h03;
    localparam int IDX_FAST_CTRL = 'h10;
    localparam int IDX_TRIM_A = 'h11;
    localparam int IDX_TRIM_B = 'h12;
    localparam int IDX_LP_CTRL = 'h18;
    localparam int IDX_XTAL_CTRL = 'h1c;
    localparam logic [7:0] A_CTRL_A = 8'(4 * IDX_CTRL_A);
    localparam logic [7:0] A_CTRL_B = 8'(4 * IDX_CTRL_B);
    localparam logic [7:0] A_LOCK = 8'(4 * IDX_LOCK);
    localparam logic [7:0] A_STATUS = 8'(4 * IDX_STATUS);
    localparam logic [7:0] A_FAST_CTRL = 8'(4 * IDX_FAST_CTRL);
    localparam logic [7:0] A_TRIM_A = 8'(4 * IDX_TRIM_A);
    localparam logic [7:0] A_TRIM_B = 8'(4 * IDX_TRIM_B);
    localparam logic [7:0] A_LP_CTRL = 8'(4 * IDX_LP_CTRL);
    localparam logic [7:0] A_XTAL_CTRL = 8'(4 * IDX_XTAL_CTRL);
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CLOCK_OUT_PIN_BIT = 7;
    localparam int FLOCK_BIT = 7;
    localparam int STDBY_BIT = 1;
    localparam int XEN_BIT = 0;
    localparam int XSEL_BIT = 2;
    localparam int CRYSTAL_STARTUP_TIME_LSB = 4;
    localparam int PRESCALE_DIVISION_LSB = 1;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h11;
    // ----------------------------------------
    // source codes and counts
    // ----------------------------------------
    localparam logic [1:0] SRC_FAST = 2'h0;
    localparam logic [1:0] SRC_LP = 2'h1;
    localparam logic [1:0] SRC_XTAL = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;
    localparam logic [15:0] TAIL_CYC = 16'h0004;
    localparam logic [15:0] EXT_SU_CYC = 16'h0002;
    localparam logic [4:0] TICK_LAST = 5'h1f;

    typedef struct packed {
        logic [1:0] freq_choice;
        logic osc_lock;
        logic [3:0][5:0] centre;
        logic [3:0][3:0] temp;
    } fuse_t;
endpackage : clock_ctl_pkg

// ---- logic/clock_ctl.sv ----
// clock controller: trims, start-up gates, protected registers, clock-out gate
//
// Overview of operation
// R1: at reset load both trims from fuses picked by the fused frequency choice
// R2: centre trim is six bits in trim register A
// R3: temperature slope trim is four bits in trim register B
// R4: osc lock fuse set makes trim writes ineffective
// R5: trims also locked while fast osc is main source and lock enable set
// R6: fast osc gate opens after analog start-up plus four osc cycles
// R7: software slows main clock prescaler around trim changes
// R8: low-power osc supplies a 1.024 kHz tick
// R9: low-power osc gate opens after start-up plus four osc cycles
// R10: a request for the pin clock reconfigures its pin as clock input
// R11: pin clock becomes usable after two of its cycles
// R12: software picks crystal or external clock with the select bit
// R13: crystal runs only when enabled; enable overrides both crystal pins
// R14: crystal start-up length set by the two-bit start-up field
// R15: crystal in external-clock mode starts in fixed two cycles
// R16: software writes key then protected bits within four instructions
// R17: protected write without unlock leaves the register unchanged
// R18: all clock, lock, oscillator and trim registers are protected
// R19: clock-out bit puts system clock on the clock-out pin
// R20: asleep, no clock out unless a peripheral uses the system clock
// R21: source select codes 0..3: fast, low-power, crystal, pin clock
// R22: prescaler off passes main clock; on, division field picks ratio
// R23: lock enable freezes main controls, active trims and itself till reset
// R24: protected writes accepted only while the cpu open qualifier is high
// R25: each gate stays closed until its own osc-cycle counter expires
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module clock_ctl
    import clock_ctl_pkg::*;
#(
    parameter logic [15:0] XTAL_SU0 = 16'h0400,
    parameter logic [15:0] XTAL_SU1 = 16'h1000,
    parameter logic [15:0] XTAL_SU2 = 16'h4000,
    parameter logic [15:0] XTAL_SU3 = 16'h8000
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // cpu protection qualifier and fuses
    input wire logic PROT_OPEN,
    input wire fuse_t FUSE,
    // oscillators, index = source code
    input wire logic [3:0] OSC_CLK,
    input wire logic [1:0] ANALOG_RDY,
    input wire logic [3:0] PERIPH_REQ,
    // sleep
    input wire logic SLEEP,
    input wire logic SYSCLK_IN_USE,
    // controls out
    output logic [3:0] GATE_OPEN,
    output logic TICK_1K,
    output logic EXT_PIN_CFG,
    output logic XTAL_PIN_OVR,
    output logic XTAL_EXT_MODE,
    output logic CLK_OUT_EN,
    output logic [1:0] MAIN_SEL,
    output logic [6:0] PER_DIV,
    output logic [5:0] CENTRE_TRIM,
    output logic [3:0] TEMP_TRIM
);
    typedef struct packed {
        logic loaded;
        logic clock_out_pin;
        logic [1:0] src;
        logic [3:0] prescale_division;
        logic prescale_enable;
        logic lock_en;
        logic fast_stdby;
        logic lp_stdby;
        logic [5:0] ctrim;
        logic [3:0] ttrim;
        logic fuse_lock;
        logic [1:0] crystal_startup_time;
        logic xsel;
        logic xstdby;
        logic xen;
        logic [3:0] osc_prev;
        logic [3:0] open;
        logic [3:0][15:0] cnt;
        logic [4:0] tick_div;
        logic tick;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic clk_out_en;
        logic ext_cfg;
        logic xtal_ovr;
        logic [6:0] per_div;
    } state_t;

    state_t s;
    state_t n;
    logic [3:0] req;
    logic [3:0] ana;
    logic [3:0] edg;
    logic [3:0][15:0] lim;
    logic acc;
    logic wr_try;
    logic wr;
    logic cal_lk;
    logic [5:0] fuse_c;
    logic [3:0] fuse_t_trim;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic is_reg(input logic [7:0] a);
        return a == A_CTRL_A || a == A_CTRL_B || a == A_LOCK || a == A_STATUS ||
               a == A_FAST_CTRL || a == A_TRIM_A || a == A_TRIM_B ||
               a == A_LP_CTRL || a == A_XTAL_CTRL;
    endfunction : is_reg

    // reserved division codes fall back to 2
    function automatic logic [6:0] div_factor(input logic [3:0] d);
        case (d)
            4'h1: return 7'h04;
            4'h2: return 7'h08;
            4'h3: return 7'h10;
            4'h4: return 7'h20;
            4'h5: return 7'h40;
            4'h8: return 7'h06;
            4'h9: return 7'h0a;
            4'ha: return 7'h0c;
            4'hb: return 7'h18;
            4'hc: return 7'h30;
            default: return 7'h02;
        endcase
    endfunction : div_factor

    function automatic logic [7:0] rd_reg(input logic [7:0] a, input state_t t);
        logic [7:0] v;
        v = 8'h00;
        if (a == A_CTRL_A) begin
            v = {t.clock_out_pin, 5'h00, t.src};
        end else if (a == A_CTRL_B) begin
            v = {3'h0, t.prescale_division, t.prescale_enable};
        end else if (a == A_LOCK) begin
            v = {7'h00, t.lock_en};
        end else if (a == A_STATUS) begin
            v = {t.open, 3'h0, !t.open[t.src]};
        end else if (a == A_FAST_CTRL) begin
            v = {6'h00, t.fast_stdby, 1'b0};
        end else if (a == A_TRIM_A) begin
            v = {2'h0, t.ctrim};
        end else if (a == A_TRIM_B) begin
            v = {t.fuse_lock, 3'h0, t.ttrim};
        end else if (a == A_LP_CTRL) begin
            v = {6'h00, t.lp_stdby, 1'b0};
        end else if (a == A_XTAL_CTRL) begin
            v = {2'h0, t.crystal_startup_time, 1'b0, t.xsel, t.xstdby, t.xen};
        end
        return v;
    endfunction : rd_reg

    // ----------------------------------------
    // requests and start-up limits
    // ----------------------------------------
    assign fuse_c = FUSE.centre[FUSE.freq_choice];
    assign fuse_t_trim = FUSE.temp[FUSE.freq_choice];
    assign req[0] = PERIPH_REQ[0] | s.src == SRC_FAST;
    assign req[1] = PERIPH_REQ[1] | s.src == SRC_LP;
    assign req[2] = (PERIPH_REQ[2] | s.src == SRC_XTAL) & s.xen; // [R13]
    assign req[3] = PERIPH_REQ[3] | s.src == SRC_EXT;
    // run in standby keeps the analog part warm, so its wait is skipped
    assign ana = {2'b11, ANALOG_RDY[1] | s.lp_stdby, ANALOG_RDY[0] | s.fast_stdby}; // [R6] [R9]
    assign edg = OSC_CLK & ~s.osc_prev;
    assign lim[0] = TAIL_CYC; // [R6]
    assign lim[1] = TAIL_CYC; // [R9]
    assign lim[2] = s.xsel ? EXT_SU_CYC : // [R15]
                    s.crystal_startup_time == 2'h0 ? XTAL_SU0 : s.crystal_startup_time == 2'h1 ? XTAL_SU1 : // [R14]
                    s.crystal_startup_time == 2'h2 ? XTAL_SU2 : XTAL_SU3;
    assign lim[3] = EXT_SU_CYC; // [R11]
    assign acc = PSEL & PENABLE;
    assign wr_try = acc & s.pready & PWRITE;
    assign wr = wr_try & PROT_OPEN & s.loaded; // [R24] [R17] [R18]
    assign cal_lk = s.fuse_lock | (s.lock_en & s.src == SRC_FAST); // [R4] [R5] [R23]

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = s;
        n.loaded = 1'b1;
        if (!s.loaded) begin
            n.ctrim = fuse_c; // [R1]
            n.ttrim = fuse_t_trim; // [R1]
            n.fuse_lock = FUSE.osc_lock;
            n.lock_en = FUSE.osc_lock;
        end
        // one wait state: pready rises in the second access cycle
        n.pready = acc & !s.pready;
        n.prdata = 32'h0000_0000;
        n.pslverr = 1'b0;
        if (acc && !s.pready) begin
            n.prdata = {24'h00_0000, rd_reg(PADDR, s)};
            n.pslverr = !is_reg(PADDR);
        end
        if (wr) begin
            if (PADDR == A_CTRL_A && !s.lock_en) begin // [R23]
                n.clock_out_pin = PWDATA[CLOCK_OUT_PIN_BIT]; // [R19]
                n.src = PWDATA[1:0]; // [R21]
            end else if (PADDR == A_CTRL_B && !s.lock_en) begin
                n.prescale_division = PWDATA[PRESCALE_DIVISION_LSB +: 4]; // [R22]
                n.prescale_enable = PWDATA[0];
            end else if (PADDR == A_LOCK && !s.lock_en) begin
                n.lock_en = PWDATA[0]; // [R23]
            end else if (PADDR == A_FAST_CTRL) begin
                n.fast_stdby = PWDATA[STDBY_BIT];
            end else if (PADDR == A_TRIM_A && !cal_lk) begin
                n.ctrim = PWDATA[5:0]; // [R2]
            end else if (PADDR == A_TRIM_B && !cal_lk) begin
                n.ttrim = PWDATA[3:0]; // [R3]
            end else if (PADDR == A_LP_CTRL) begin
                n.lp_stdby = PWDATA[STDBY_BIT];
            end else if (PADDR == A_XTAL_CTRL) begin
                n.crystal_startup_time = PWDATA[CRYSTAL_STARTUP_TIME_LSB +: 2];
                n.xsel = PWDATA[XSEL_BIT];
                n.xstdby = PWDATA[STDBY_BIT];
                n.xen = PWDATA[XEN_BIT];
            end
        end
        // start-up counters count the oscillator's own edges
        n.osc_prev = OSC_CLK;
        for (int i = 0; i < 4; i++) begin
            if (!req[i]) begin
                n.cnt[i] = 16'h0000;
                n.open[i] = 1'b0;
            end else if (!ana[i]) begin
                n.cnt[i] = 16'h0000;
            end else if (s.cnt[i] == lim[i]) begin
                n.open[i] = 1'b1; // [R25]
            end else if (edg[i]) begin
                n.cnt[i] = s.cnt[i] + 16'h0001;
            end
        end
        // 32 low-power cycles per tick gives 1.024 kHz
        n.tick = 1'b0;
        if (s.open[SRC_LP] && edg[SRC_LP]) begin
            n.tick_div = s.tick_div + 5'h01;
            n.tick = s.tick_div == TICK_LAST; // [R8]
        end
        n.ext_cfg = req[SRC_EXT]; // [R10]
        n.xtal_ovr = s.xen; // [R13]
        n.clk_out_en = s.clock_out_pin & (!SLEEP | SYSCLK_IN_USE); // [R19] [R20]
        n.per_div = s.prescale_enable ? div_factor(s.prescale_division) : 7'h01; // [R22]
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s <= '0;
            s.clock_out_pin <= CTRL_A_RST[CLOCK_OUT_PIN_BIT];
            s.prescale_division <= CTRL_B_RST[PRESCALE_DIVISION_LSB +: 4];
            s.prescale_enable <= CTRL_B_RST[0];
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign GATE_OPEN = s.open;
    assign TICK_1K = s.tick;
    assign EXT_PIN_CFG = s.ext_cfg;
    assign XTAL_PIN_OVR = s.xtal_ovr;
    assign XTAL_EXT_MODE = s.xsel;
    assign CLK_OUT_EN = s.clk_out_en;
    assign MAIN_SEL = s.src;
    assign PER_DIV = s.per_div;
    assign CENTRE_TRIM = s.ctrim;
    assign TEMP_TRIM = s.ttrim;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence fast_full;
        req[0] && ana[0] && s.cnt[0] == TAIL_CYC;
    endsequence
    sequence fast_opened;
        s.open[0] ##1 s.open[0] || !req[0];
    endsequence

    fuse_load_a: assert property ($rose(s.loaded) |-> s.ctrim == $past(fuse_c) // [R1]
        && s.ttrim == $past(fuse_t_trim)) else $error("trims not loaded from fuse");
    trim_frozen_a: assert property (s.loaded && s.fuse_lock |=> $stable(s.ctrim) // [R4]
        && $stable(s.ttrim)) else $error("trim changed under fuse lock");
    src_lock_a: assert property (s.loaded && s.lock_en && s.src == SRC_FAST // [R5]
        |=> $stable(s.ctrim)) else $error("active trim changed while locked");
    main_lock_a: assert property (s.loaded && s.lock_en |=> $stable(s.src) // [R23]
        && $stable(s.prescale_division) && s.lock_en) else $error("main control changed while locked");
    fast_gate_a: assert property (fast_full |=> fast_opened) // [R6]
        else $error("fast gate late");
    fast_early_a: assert property ($rose(s.open[0]) |-> $past(s.cnt[0]) == TAIL_CYC) // [R6]
        else $error("fast gate early");
    lp_gate_a: assert property ($rose(s.open[1]) |-> $past(s.cnt[1]) == TAIL_CYC) // [R9]
        else $error("low-power gate count wrong");
    tick_rate_a: assert property (TICK_1K |-> s.open[1] && s.tick_div == 5'h00) // [R8]
        else $error("tick out of step");
    ext_pin_a: assert property (PERIPH_REQ[3] |=> EXT_PIN_CFG) // [R10]
        else $error("pin not given to clock");
    ext_su_a: assert property ($rose(s.open[3]) |-> $past(s.cnt[3]) == EXT_SU_CYC) // [R11]
        else $error("pin clock start-up wrong");
    xtal_fix_a: assert property ($rose(s.open[2]) && $past(s.xsel) // [R15]
        |-> $past(s.cnt[2]) == EXT_SU_CYC) else $error("crystal ext start-up wrong");
    xtal_en_a: assert property (!s.xen |=> !s.open[2] && !XTAL_PIN_OVR) // [R13]
        else $error("crystal runs while disabled");
    prot_write_a: assert property (wr_try && !PROT_OPEN |=> $stable(s.src) // [R17]
        && $stable(s.prescale_division) && $stable(s.ctrim) && $stable(s.xen) && $stable(s.lock_en))
        else $error("unprotected write took effect");
    sleep_out_a: assert property (SLEEP && !SYSCLK_IN_USE |=> !CLK_OUT_EN) // [R20]
        else $error("clock out while asleep");
    clk_out_a: assert property (s.clock_out_pin && !SLEEP |=> CLK_OUT_EN) // [R19]
        else $error("clock out missing");
    div_off_a: assert property (!s.prescale_enable |=> PER_DIV == 7'h01) // [R22]
        else $error("prescaler off but dividing");
endmodule : clock_ctl

// ---- bench/osc_model.sv ----
// far-side model: free-running oscillator sources and analog start-up ready
`timescale 1ns/1ps
module osc_model #(
    parameter int RDY_DLY = 24
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // requests of the two internal oscillators, sources, analog ready
    input wire logic [1:0] REQ,
    output logic [3:0] OSC,
    output logic [1:0] RDY
);
    // ----
    // half periods in system cycles: fast, low-power, crystal, pin clock
    // ----
    localparam int HALF [4] = '{2, 3, 5, 4};
    int ph [4];
    int dly [2];
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            OSC <= 4'h0;
            RDY <= 2'h0;
            ph = '{0, 0, 0, 0};
            dly = '{0, 0};
        end else begin
            for (int i = 0; i < 4; i++) begin
                ph[i] = (ph[i] + 1) % HALF[i];
                if (ph[i] == 0) OSC[i] <= ~OSC[i];
            end
            // a dropped request restarts the analog start-up
            for (int i = 0; i < 2; i++) begin
                dly[i] = REQ[i] ? dly[i] + 1 : 0;
                RDY[i] <= (dly[i] >= RDY_DLY);
            end
        end
    end
endmodule : osc_model

// ---- bench/testbench.sv ----
// testbench: registers, start-up gates, locks and clock-out of the clock controller
`timescale 1ns/1ps
module testbench;
    import clock_ctl_pkg::*;
    // ----
    // signals
    // ----
    logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic PROT_OPEN = 1'b0, SLEEP = 1'b0, SYSCLK_IN_USE = 1'b0, PREADY, PSLVERR;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [3:0] OSC_CLK, GATE_OPEN, PERIPH_REQ = 4'h1;
    logic [1:0] ANALOG_RDY, MAIN_SEL;
    logic TICK_1K, EXT_PIN_CFG, XTAL_PIN_OVR, XTAL_EXT_MODE, CLK_OUT_EN;
    logic [6:0] PER_DIV;
    logic [5:0] CENTRE_TRIM;
    logic [3:0] TEMP_TRIM;
    fuse_t FUSE = '{2'h1, 1'b0, {6'h31, 6'h22, 6'h13, 6'h04}, {4'hd, 4'hc, 4'hb, 4'ha}};
    logic [7:0] rd, old;
    logic er;
    int miscompares = 0, tests_run = 0, n;
    int div_tab [13] = '{2, 4, 8, 16, 32, 64, 2, 2, 6, 10, 12, 24, 48};
    logic [7:0] pa [8] = '{A_CTRL_A, A_CTRL_B, A_LOCK, A_FAST_CTRL, A_TRIM_A, A_TRIM_B,
                           A_LP_CTRL, A_XTAL_CTRL};
    always #5 CLK = ~CLK;
    // the model sees main-source use as a request too, as the real oscillator would
    osc_model u_osc (.CLK(CLK), .RST(RST), .OSC(OSC_CLK), .RDY(ANALOG_RDY),
        .REQ({PERIPH_REQ[1] | (MAIN_SEL == SRC_LP), PERIPH_REQ[0] | (MAIN_SEL == SRC_FAST)}));
    clock_ctl #(.XTAL_SU0(16'h0004), .XTAL_SU1(16'h0005), .XTAL_SU2(16'h0006),
        .XTAL_SU3(16'h0007)) uut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .PROT_OPEN(PROT_OPEN), .FUSE(FUSE), .OSC_CLK(OSC_CLK),
        .ANALOG_RDY(ANALOG_RDY), .PERIPH_REQ(PERIPH_REQ), .SLEEP(SLEEP),
        .SYSCLK_IN_USE(SYSCLK_IN_USE), .GATE_OPEN(GATE_OPEN), .TICK_1K(TICK_1K),
        .EXT_PIN_CFG(EXT_PIN_CFG), .XTAL_PIN_OVR(XTAL_PIN_OVR), .XTAL_EXT_MODE(XTAL_EXT_MODE),
        .CLK_OUT_EN(CLK_OUT_EN), .MAIN_SEL(MAIN_SEL), .PER_DIV(PER_DIV),
        .CENTRE_TRIM(CENTRE_TRIM), .TEMP_TRIM(TEMP_TRIM));
    // ----
    // tasks
    // ----
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %0t %s: got %0h want %0h", $time, what, got, exp);
            miscompares++;
        end
    endtask : chk
    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic open);
        int k;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {24'h0, d};
        PROT_OPEN <= open;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 50);
        rd = PRDATA[7:0];
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        PROT_OPEN <= 1'b0;
        if (PREADY !== 1'b1) begin
            $display("[FAIL] %0t apb transfer timed out", $time);
            miscompares++;
            wrap_up();
        end
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
        apb(1'b0, a, 8'h00, 1'b0);
        chk(rd, e, what);
    endtask : rdc
    task automatic settle;
        repeat (3) @(posedge CLK);
    endtask : settle
    task automatic do_reset;
        RST <= 1'b1;
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
    endtask : do_reset
    // gate must stay shut until lim counted source edges, then open within one more
    task automatic gate_wait(input int i, input int lim);
        int rises;
        logic prev;
        rises = 0;
        prev = OSC_CLK[i];
        for (int k = 0; k < 3000 && GATE_OPEN[i] !== 1'b1; k++) begin
            @(posedge CLK);
            if (OSC_CLK[i] && !prev && (i > 1 || ANALOG_RDY[i[0]])) rises++;
            prev = OSC_CLK[i];
        end
        chk(GATE_OPEN[i], 1, "gate open");
        chk(rises >= lim && rises <= lim + 1, 1, "gate edge count");
    endtask : gate_wait
    // ----
    // main sequence
    // ----
    initial begin
        do_reset();
        gate_wait(0, 4);
        rdc(A_CTRL_A, CTRL_A_RST, "ctrl a reset");
        rdc(A_CTRL_B, CTRL_B_RST, "ctrl b reset");
        chk(PER_DIV, 6, "reset division");
        rdc(A_TRIM_A, 8'h13, "centre fuse");
        rdc(A_TRIM_B, 8'h0b, "slope fuse");
        chk({CENTRE_TRIM, TEMP_TRIM}, 10'h13b, "trims out");
        $display("test reset done");
        foreach (pa[j]) begin
            apb(1'b0, pa[j], 8'h00, 1'b0);
            old = rd;
            apb(1'b1, pa[j], ~old, 1'b0);
            rdc(pa[j], old, "unprotected write");
        end
        apb(1'b0, A_STATUS, 8'h00, 1'b0);
        old = rd;
        apb(1'b1, A_STATUS, ~old, 1'b1);
        rdc(A_STATUS, old, "status read-only");
        apb(1'b0, 8'h14, 8'h00, 1'b0);
        chk(er, 1, "unmapped error");
        $display("test protection done");
        apb(1'b1, A_CTRL_B, 8'h0b, 1'b1);
        settle();
        chk(PER_DIV, 64, "slowed for trim");
        apb(1'b1, A_TRIM_A, 8'h2a, 1'b1);
        apb(1'b1, A_TRIM_B, 8'h85, 1'b1);
        apb(1'b1, A_CTRL_B, CTRL_B_RST, 1'b1);
        settle();
        chk({CENTRE_TRIM, TEMP_TRIM}, 10'h2a5, "trims written");
        rdc(A_TRIM_B, 8'h05, "fuse lock bit");
        for (int c = 0; c < 13; c++) begin
            apb(1'b1, A_CTRL_B, 8'((c << 1) | 1), 1'b1);
            settle();
            chk(PER_DIV, div_tab[c], "division");
        end
        apb(1'b1, A_CTRL_B, 8'h18, 1'b1);
        settle();
        chk(PER_DIV, 1, "prescaler off");
        apb(1'b1, A_CTRL_A, 8'h80, 1'b1);
        settle();
        chk(CLK_OUT_EN, 1, "clock out");
        SLEEP <= 1'b1;
        settle();
        chk(CLK_OUT_EN, 0, "asleep");
        SYSCLK_IN_USE <= 1'b1;
        settle();
        chk(CLK_OUT_EN, 1, "asleep in use");
        SLEEP <= 1'b0;
        $display("test registers done");
        PERIPH_REQ <= 4'h3;
        gate_wait(1, 4);
        n = 0;
        repeat (768) begin
            @(posedge CLK);
            if (TICK_1K === 1'b1) n++;
        end
        chk(n, 4, "tick count");
        // request and edge count start together, so no pin-clock edge is missed
        PERIPH_REQ <= 4'hb;
        gate_wait(3, 2);
        chk(EXT_PIN_CFG, 1, "pin as clock input");
        PERIPH_REQ <= 4'h7;
        repeat (200) @(posedge CLK);
        chk(GATE_OPEN[3:2], 2'b00, "gates shut");
        for (int k = 0; k < 5; k++) begin
            PERIPH_REQ <= 4'h3;
            apb(1'b1, A_XTAL_CTRL, (k < 4) ? 8'((k << 4) | 1) : 8'h35, 1'b1);
            settle();
            chk({XTAL_PIN_OVR, XTAL_EXT_MODE}, {1'b1, k == 4}, "crystal pins");
            PERIPH_REQ <= 4'h7;
            gate_wait(2, (k < 4) ? 4 + k : 2);
        end
        $display("test start-up done");
        apb(1'b1, A_LOCK, 8'h01, 1'b1);
        apb(1'b1, A_CTRL_A, 8'h01, 1'b1);
        rdc(A_CTRL_A, 8'h80, "ctrl frozen");
        apb(1'b1, A_TRIM_A, 8'h07, 1'b1);
        rdc(A_TRIM_A, 8'h2a, "trim frozen");
        apb(1'b1, A_LOCK, 8'h00, 1'b1);
        rdc(A_LOCK, 8'h01, "lock held");
        do_reset();
        for (int s = 1; s < 4; s++) begin
            apb(1'b1, A_CTRL_A, 8'(s), 1'b1);
            settle();
            chk(MAIN_SEL, s, "source select");
        end
        FUSE.osc_lock <= 1'b1;
        do_reset();
        rdc(A_TRIM_B, 8'h8b, "fuse lock read");
        apb(1'b1, A_TRIM_A, 8'h3f, 1'b1);
        settle();
        chk(CENTRE_TRIM, 6'h13, "fuse lock holds");
        $display("test locks done");
        wrap_up();
    end
endmodule : testbench
